/* File: intc_flag_regs.sv */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Nesting disable at bit 15 of the global control register, when 1, forbids nested interrupts.
// - Math, address, stack and oscillator traps set status bits 4, 3, 2 and 1 of the global control register.
// - Each external input fires on the negative edge when its polarity bit is 1, else on the positive edge.
// - A flag reads 1 once its source has requested and 0 while no request has occurred.
// - Flag register 0 holds converter 13, serial1 tx 12, rx 11, sync1 event 10, fault 9 and timer three 8.
// - Flag register 0 also holds timer two 7, compare2 6, capture2 5, timer one 3, compare1 2, capture1 1, ext0 0.
// - Flag register 1 holds serial2 tx 15, rx 14, ext2 13, timer five 12, timer four 11, compare4 10, compare3 9.
// - Flag register 1 also holds ext1 4, change notify 3, comparator 2, twowire1 master 1 and slave 0.
// - Flag register 2 holds parallel port 13, compare5 9, captures 5/4/3 at 7/6/5, sync2 event 1 and fault 0.
// - Flag register 3 holds calendar 14, twowire2 master 2 and slave 1, nothing else.
// - Unimplemented bits read zero and ignore writes.
// - Hardware sets flags from their sources and software clears them after service.
// - The alternate vector select bit chooses the standard or alternate vector table.
// - While nesting is disabled the CPU priority level is read-only.
module intc_flag_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [2:0] arith_trap_in,
  input wire logic [2:0] ext_pin_in,
  input wire logic [63:0] periph_req_in,
  input wire logic arith_trap_status_in,
  input wire logic addr_trap_status_in,
  input wire logic stack_trap_status_in,
  input wire logic osc_fail_trap_status_in,
  input wire logic repeat_disable_active_in,
  output logic [15:0] rdata_out,
  output logic nesting_disable_out,
  output logic priority_level_lock_out,
  output logic alt_vector_select_out,
  output logic [63:0] request_flags_out
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic [15:0] global_control;
  logic [15:0] vector_polarity;
  logic [63:0] flags;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [63:0] hw_set;
  logic [63:0] sw_data;
  logic [63:0] sw_write;
  logic [63:0] flag_mask;
  logic [63:0] next_flags;
  logic [15:0] next_global_control;
  logic [15:0] trap_set;
  logic [15:0] read_mux;
  logic wr_global;
  logic wr_vector;
  logic [3:0] wr_flag;
  logic [2:0] ext_edge;

  edge_detect_if edge_bus ();

  ext_edge_detect edge_unit (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .port(edge_bus.det)
  );

  function automatic logic [15:0] flag_word(input logic [63:0] v, input logic [1:0] k);
    flag_word = v[k * 16 +: 16];
  endfunction

  assign edge_bus.pin_sync = pin_sync;
  assign edge_bus.polarity = {vector_polarity[intc_flags_pkg::POS_EXT2_POLARITY],
                              vector_polarity[intc_flags_pkg::POS_EXT1_POLARITY],
                              vector_polarity[intc_flags_pkg::POS_EXT0_POLARITY]};
  assign ext_edge = edge_bus.edge_seen;

  assign wr_global = write_in && (addr_in == intc_flags_pkg::IDX_GLOBAL_CONTROL);
  assign wr_vector = write_in && (addr_in == intc_flags_pkg::IDX_VECTOR_POLARITY);
  assign wr_flag[0] = write_in && (addr_in == intc_flags_pkg::IDX_REQUEST_FLAGS_0);
  assign wr_flag[1] = write_in && (addr_in == intc_flags_pkg::IDX_REQUEST_FLAGS_1);
  assign wr_flag[2] = write_in && (addr_in == intc_flags_pkg::IDX_REQUEST_FLAGS_2);
  assign wr_flag[3] = write_in && (addr_in == intc_flags_pkg::IDX_REQUEST_FLAGS_3);

  // Layout of the 35 implemented flag bits across the four flag words.
  assign flag_mask = {intc_flags_pkg::MASK_REQUEST_FLAGS_3, intc_flags_pkg::MASK_REQUEST_FLAGS_2,
                      intc_flags_pkg::MASK_REQUEST_FLAGS_1, intc_flags_pkg::MASK_REQUEST_FLAGS_0};

  // External inputs land on ext0 (word 0 bit 0), ext1 (word 1 bit 4) and ext2 (word 1 bit 13).
  always_comb begin
    hw_set = periph_req_in;
    hw_set[0] = ext_edge[0];
    hw_set[20] = ext_edge[1];
    hw_set[29] = ext_edge[2];
  end

  assign sw_data = {4{wdata_in}};
  assign sw_write = {{16{wr_flag[3]}}, {16{wr_flag[2]}}, {16{wr_flag[1]}}, {16{wr_flag[0]}}};

  // A hardware set in the same cycle as a software clear wins, so no request is lost.
  assign next_flags = ((sw_write & sw_data) | (~sw_write & flags) | hw_set) & flag_mask;

  assign trap_set = {11'h000, arith_trap_status_in, addr_trap_status_in, stack_trap_status_in,
                     osc_fail_trap_status_in, 1'b0};
  assign next_global_control = ((wr_global ? wdata_in : global_control) | trap_set)
                               & intc_flags_pkg::MASK_GLOBAL_CONTROL;

  always_comb begin
    read_mux = 16'h0000;
    unique case (addr_in)
      intc_flags_pkg::IDX_GLOBAL_CONTROL: read_mux = global_control;
      intc_flags_pkg::IDX_VECTOR_POLARITY: read_mux = vector_polarity
        | (16'(repeat_disable_active_in) << intc_flags_pkg::POS_REPEAT_DISABLE);
      intc_flags_pkg::IDX_REQUEST_FLAGS_0: read_mux = flag_word(flags, 2'd0);
      intc_flags_pkg::IDX_REQUEST_FLAGS_1: read_mux = flag_word(flags, 2'd1);
      intc_flags_pkg::IDX_REQUEST_FLAGS_2: read_mux = flag_word(flags, 2'd2);
      intc_flags_pkg::IDX_REQUEST_FLAGS_3: read_mux = flag_word(flags, 2'd3);
      default: read_mux = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= ext_pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      global_control <= intc_flags_pkg::RESET_VALUE;
      vector_polarity <= intc_flags_pkg::RESET_VALUE;
      flags <= 64'h0000_0000_0000_0000;
    end else begin
      global_control <= next_global_control;
      if (wr_vector) begin
        vector_polarity <= wdata_in & intc_flags_pkg::MASK_VECTOR_POLARITY;
      end
      flags <= next_flags;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
      nesting_disable_out <= 1'b0;
      priority_level_lock_out <= 1'b0;
      alt_vector_select_out <= 1'b0;
      request_flags_out <= 64'h0000_0000_0000_0000;
    end else begin
      rdata_out <= read_in ? read_mux : 16'h0000;
      nesting_disable_out <= next_global_control[intc_flags_pkg::POS_NESTING_DISABLE];
      priority_level_lock_out <= next_global_control[intc_flags_pkg::POS_NESTING_DISABLE];
      alt_vector_select_out <= wr_vector ? wdata_in[intc_flags_pkg::POS_ALT_VECTOR_SELECT]
                                         : alt_vector_select_out;
      request_flags_out <= next_flags;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_NEST_FOLLOWS_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_global |=> nesting_disable_out == $past(wdata_in[15]))
    else $error("Nesting disable output did not follow the written bit.");

  AST_LOCK_MATCHES_NEST: assert property (@(posedge clock_in) disable iff (rst_in)
    priority_level_lock_out == nesting_disable_out)
    else $error("Priority lock differs from nesting disable.");

  AST_TRAP_SETS: assert property (@(posedge clock_in) disable iff (rst_in)
    stack_trap_status_in |=> global_control[intc_flags_pkg::POS_STACK_TRAP])
    else $error("Stack trap did not set its status bit.");

  AST_HW_SET_WINS: assert property (@(posedge clock_in) disable iff (rst_in)
    (periph_req_in[13] && wr_flag[0] && !wdata_in[13]) |=> request_flags_out[13])
    else $error("Request lost against a software clear.");

  AST_SW_SET: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[1] && wdata_in[15]) |=> flags[31])
    else $error("Software write of 1 did not set the flag.");

  AST_UNIMPL_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
    (flags & ~flag_mask) == 64'h0000_0000_0000_0000)
    else $error("Unimplemented flag bit is set.");

  AST_FLAG_HOLDS: assert property (@(posedge clock_in) disable iff (rst_in)
    (flags[8] && !wr_flag[0]) |=> flags[8])
    else $error("Flag cleared without a software write.");

  AST_READ_LATENCY: assert property (@(posedge clock_in) disable iff (rst_in)
    (read_in && addr_in == intc_flags_pkg::IDX_VECTOR_POLARITY && repeat_disable_active_in) |=> rdata_out[14])
    else $error("Repeat-disable status not returned on read.");

  AST_FLAG3_LAYOUT: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[3] && wdata_in == 16'hffff && periph_req_in[63:48] == 16'h0000) |=> flags[63:48] == 16'h4006)
    else $error("Flag register 3 layout wrong.");

  // ---------------------------------------------------------------------------
  // Global control checks
  // ---------------------------------------------------------------------------
  // Trap inputs are events, not levels, so each trap check looks one cycle after the event.
  AST_NEST_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_global && !wdata_in[15]) |=> !nesting_disable_out)
    else $error("Nesting disable did not clear on write of zero.");

  AST_NEST_HOLDS: assert property (@(posedge clock_in) disable iff (rst_in)
    !wr_global |=> $stable(nesting_disable_out))
    else $error("Nesting disable changed without a write.");

  AST_ARITH_TRAP_SETS: assert property (@(posedge clock_in) disable iff (rst_in)
    arith_trap_status_in |=> global_control[intc_flags_pkg::POS_ARITH_TRAP])
    else $error("Math trap did not set its status bit.");

  AST_ADDR_TRAP_SETS: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_trap_status_in |=> global_control[intc_flags_pkg::POS_ADDR_TRAP])
    else $error("Address trap did not set its status bit.");

  AST_OSC_TRAP_SETS: assert property (@(posedge clock_in) disable iff (rst_in)
    osc_fail_trap_status_in |=> global_control[intc_flags_pkg::POS_OSC_FAIL_TRAP])
    else $error("Oscillator trap did not set its status bit.");

  AST_GLOBAL_UNIMPL: assert property (@(posedge clock_in) disable iff (rst_in)
    (global_control & ~intc_flags_pkg::MASK_GLOBAL_CONTROL) == 16'h0000)
    else $error("Unimplemented global control bit is set.");

  AST_LOCK_FOLLOWS: assert property (@(posedge clock_in) disable iff (rst_in)
    priority_level_lock_out == global_control[intc_flags_pkg::POS_NESTING_DISABLE])
    else $error("Priority lock differs from the stored nesting bit.");

  // ---------------------------------------------------------------------------
  // Vector and polarity checks
  // ---------------------------------------------------------------------------
  // The repeat-disable bit is never stored; it is a live view of the core's countdown.
  AST_VECTOR_UNIMPL: assert property (@(posedge clock_in) disable iff (rst_in)
    (vector_polarity & ~intc_flags_pkg::MASK_VECTOR_POLARITY) == 16'h0000)
    else $error("Unimplemented vector control bit is set.");

  AST_REPEAT_NOT_STORED: assert property (@(posedge clock_in) disable iff (rst_in)
    !vector_polarity[intc_flags_pkg::POS_REPEAT_DISABLE])
    else $error("Repeat-disable status was stored by a write.");

  AST_REPEAT_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
    (read_in && addr_in == intc_flags_pkg::IDX_VECTOR_POLARITY && !repeat_disable_active_in)
    |=> !rdata_out[14])
    else $error("Repeat-disable status read high while inactive.");

  AST_ALT_FOLLOWS: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_vector |=> alt_vector_select_out == $past(wdata_in[15]))
    else $error("Alternate vector select did not follow the write.");

  AST_ALT_HOLDS: assert property (@(posedge clock_in) disable iff (rst_in)
    !wr_vector |=> $stable(alt_vector_select_out))
    else $error("Alternate vector select changed without a write.");

  AST_POLARITY_STORE: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_vector |=> vector_polarity[2:0] == $past(wdata_in[2:0]))
    else $error("Edge polarity selects did not take the written value.");

  // ---------------------------------------------------------------------------
  // External edge checks
  // ---------------------------------------------------------------------------
  AST_POS_EDGE: assert property (@(posedge clock_in) disable iff (rst_in)
    (!vector_polarity[0] && pin_sync[0] && !$past(pin_sync[0]) && !$past(rst_in)) |-> ext_edge[0])
    else $error("Selected positive edge was not detected.");

  AST_EXT0_FLAG: assert property (@(posedge clock_in) disable iff (rst_in)
    ext_edge[0] |=> flags[0])
    else $error("External input 0 edge did not set its flag.");

  AST_EXT1_FLAG: assert property (@(posedge clock_in) disable iff (rst_in)
    ext_edge[1] |=> flags[20])
    else $error("External input 1 edge did not set its flag.");

  AST_EXT2_FLAG: assert property (@(posedge clock_in) disable iff (rst_in)
    ext_edge[2] |=> flags[29])
    else $error("External input 2 edge did not set its flag.");

  // ---------------------------------------------------------------------------
  // Flag layout checks
  // ---------------------------------------------------------------------------
  // Writing all ones and looking at the stored word shows exactly which bits exist.
  AST_FLAG0_LAYOUT: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[0] && wdata_in == 16'hffff) |=> flags[15:0] == 16'h3fef)
    else $error("Flag register 0 layout wrong.");

  AST_FLAG1_LAYOUT: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[1] && wdata_in == 16'hffff) |=> flags[31:16] == 16'hfe1f)
    else $error("Flag register 1 layout wrong.");

  AST_FLAG2_LAYOUT: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[2] && wdata_in == 16'hffff) |=> flags[47:32] == 16'h22e3)
    else $error("Flag register 2 layout wrong.");

  AST_FLAG0_GAP: assert property (@(posedge clock_in) disable iff (rst_in)
    !flags[4])
    else $error("Unimplemented bit 4 of flag register 0 is set.");

  AST_FLAG1_GAP: assert property (@(posedge clock_in) disable iff (rst_in)
    flags[24:21] == 4'h0)
    else $error("Unimplemented bits of flag register 1 are set.");

  // ---------------------------------------------------------------------------
  // Set and clear checks
  // ---------------------------------------------------------------------------
  AST_HW_SETS: assert property (@(posedge clock_in) disable iff (rst_in)
    periph_req_in[8] |=> flags[8])
    else $error("Peripheral request did not set its flag.");

  AST_WORD2_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[2] && wdata_in == 16'h0000 && periph_req_in[47:32] == 16'h0000) |=> flags[47:32] == 16'h0000)
    else $error("Software clear of flag register 2 failed.");

  AST_WORD3_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_flag[3] && wdata_in == 16'h0000 && periph_req_in[63:48] == 16'h0000) |=> flags[63:48] == 16'h0000)
    else $error("Software clear of flag register 3 failed.");

  AST_FLAGS_OUT_COPY: assert property (@(posedge clock_in) disable iff (rst_in)
    request_flags_out == flags)
    else $error("Flag output differs from the stored flags.");

  // ---------------------------------------------------------------------------
  // Read port checks
  // ---------------------------------------------------------------------------
  // Read data is forced to zero between reads so a stale word is never mistaken for an answer.
  AST_RDATA_IDLE: assert property (@(posedge clock_in) disable iff (rst_in)
    !read_in |=> rdata_out == 16'h0000)
    else $error("Read data not zero outside a read.");

  AST_UNMAPPED_READ: assert property (@(posedge clock_in) disable iff (rst_in)
    (read_in && addr_in[2:1] == 2'b11) |=> rdata_out == 16'h0000)
    else $error("Unmapped register index returned data.");

endmodule

/* File: intc_flags_pkg.sv */
package intc_flags_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [2:0] IDX_GLOBAL_CONTROL = 3'h0;
  localparam logic [2:0] IDX_VECTOR_POLARITY = 3'h1;
  localparam logic [2:0] IDX_REQUEST_FLAGS_0 = 3'h2;
  localparam logic [2:0] IDX_REQUEST_FLAGS_1 = 3'h3;
  localparam logic [2:0] IDX_REQUEST_FLAGS_2 = 3'h4;
  localparam logic [2:0] IDX_REQUEST_FLAGS_3 = 3'h5;
  localparam int ADDR_WIDTH = 3;
  localparam int DATA_WIDTH = 16;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int POS_NESTING_DISABLE = 15;
  localparam int POS_ARITH_TRAP = 4;
  localparam int POS_ADDR_TRAP = 3;
  localparam int POS_STACK_TRAP = 2;
  localparam int POS_OSC_FAIL_TRAP = 1;
  localparam int POS_ALT_VECTOR_SELECT = 15;
  localparam int POS_REPEAT_DISABLE = 14;
  localparam int POS_EXT2_POLARITY = 2;
  localparam int POS_EXT1_POLARITY = 1;
  localparam int POS_EXT0_POLARITY = 0;

  // ---------------------------------------------------------------------------
  // Writable masks and reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MASK_GLOBAL_CONTROL = 16'h801e;
  localparam logic [15:0] MASK_VECTOR_POLARITY = 16'h8007;
  localparam logic [15:0] MASK_REQUEST_FLAGS_0 = 16'h3fef;
  localparam logic [15:0] MASK_REQUEST_FLAGS_1 = 16'hfe1f;
  localparam logic [15:0] MASK_REQUEST_FLAGS_2 = 16'h22e3;
  localparam logic [15:0] MASK_REQUEST_FLAGS_3 = 16'h4006;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // ---------------------------------------------------------------------------
  // Request flag count of the 64-bit flag vector
  // ---------------------------------------------------------------------------
  localparam int FLAG_COUNT = 64;

endpackage

/* File: edge_detect_if.sv */
`timescale 1ns/1ps
interface edge_detect_if;
  logic [2:0] pin_sync;
  logic [2:0] polarity;
  logic [2:0] edge_seen;
  modport ctrl (output pin_sync, output polarity, input edge_seen);
  modport det (input pin_sync, input polarity, output edge_seen);
endinterface

/* File: ext_edge_detect.sv */
`timescale 1ns/1ps
module ext_edge_detect (
  input wire logic clock_in,
  input wire logic rst_in,
  edge_detect_if.det port
);

  logic [2:0] last_level;
  logic [2:0] rising;
  logic [2:0] falling;

  assign rising = port.pin_sync & ~last_level;
  assign falling = ~port.pin_sync & last_level;
  // Polarity 1 selects the falling edge, 0 the rising edge.
  assign port.edge_seen = (port.polarity & falling) | (~port.polarity & rising);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      last_level <= 3'h0;
    end else begin
      last_level <= port.pin_sync;
    end
  end

  AST_EDGE_SELECT: assert property (@(posedge clock_in) disable iff (rst_in)
    (port.polarity[0] && $past(port.pin_sync[0]) && !port.pin_sync[0] && !$past(rst_in)) |-> port.edge_seen[0])
    else $error("Selected negative edge was not detected.");

endmodule

/* File: periph_model.sv */
`timescale 1ns/1ps
module periph_model (
  input wire logic clock_in,
  input wire logic fire_in,
  input wire logic [5:0] source_in,
  output logic [63:0] periph_req_out
);
  // -------------------------------------------------------------------------
  // Request pulses
  // -------------------------------------------------------------------------
  // A source raises its request only for the cycles that follow fire_in high, so the flag has to hold it.
  always_ff @(posedge clock_in) begin
    periph_req_out <= '0;
    if (fire_in) begin
      periph_req_out[source_in] <= 1'b1;
    end
  end
endmodule

/* File: intc_flag_regs_tb.sv */
`timescale 1ns/1ps
module intc_flag_regs_tb;
  logic clock_in, rst_in, write_in, read_in, fire, nest, lock, alt, repeat_dis;
  logic [2:0] addr_in, ext_pin_in, spare;
  logic [15:0] wdata_in, rdata, got, d;
  logic [5:0] src;
  logic [63:0] periph_req, flags;
  logic [3:0] traps;
  int err_total, cmp_count, fb, w;

  intc_flag_regs u_intc_flag_regs (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .arith_trap_in(spare),
    .ext_pin_in(ext_pin_in), .periph_req_in(periph_req), .arith_trap_status_in(traps[3]),
    .addr_trap_status_in(traps[2]), .stack_trap_status_in(traps[1]),
    .osc_fail_trap_status_in(traps[0]), .repeat_disable_active_in(repeat_dis),
    .rdata_out(rdata), .nesting_disable_out(nest), .priority_level_lock_out(lock),
    .alt_vector_select_out(alt), .request_flags_out(flags));
  periph_model u_periph_model (.clock_in(clock_in), .fire_in(fire), .source_in(src),
    .periph_req_out(periph_req));

  // Writable bits of each register index; unmapped indices hold nothing.
  function automatic logic [15:0] wmask(input int idx);
    case (idx)
      0: return 16'h801e;
      1: return 16'h8007;
      2: return 16'h3fef;
      3: return 16'hfe1f;
      4: return 16'h22e3;
      5: return 16'h4006;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic wr(input int a, input logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a[2:0];
    wdata_in <= v;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input int a, output logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a[2:0];
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clock_in = 0;
    forever #2 clock_in = ~clock_in;
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    err_total++;
    give_verdict();
  end

  initial begin
    {rst_in, write_in, read_in, fire, repeat_dis} = 5'b10000;
    {addr_in, ext_pin_in, wdata_in, src, traps} = '0;
    void'($urandom(32'h089c));
    spare = 3'($urandom);
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i, got);
      chk(got, 16'h0000);
    end
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        d = (k == 0) ? 16'hffff : (k == 3) ? 16'h0000 : 16'($urandom);
        wr(i, d);
        rd(i, got);
        chk(got, d & wmask(i));
        if (i == 0) chk({14'h0000, lock, nest}, {14'h0000, d[15], d[15]});
        if (i == 1) chk({15'h0000, alt}, {15'h0000, d[15]});
        if (i >= 2 && i <= 5) chk(flags[(i - 2) * 16 +: 16], d & wmask(i));
      end
    end
    $display("test registers done");
    for (int s = 0; s < 64; s++) begin
      if (s != 0 && s != 20 && s != 29) begin
        @(posedge clock_in);
        fire <= 1'b1;
        src <= s[5:0];
        @(posedge clock_in);
        fire <= 1'b0;
        repeat (2) @(posedge clock_in);
        rd(2 + s / 16, got);
        chk(got, wmask(2 + s / 16) & (16'h0001 << (s % 16)));
        wr(2 + s / 16, 16'h0000);
      end
    end
    $display("test sources done");
    for (int t = 0; t < 4; t++) begin
      @(posedge clock_in);
      traps <= 4'h1 << t;
      @(posedge clock_in);
      traps <= 4'h0;
      rd(0, got);
      chk(got, 16'h0002 << t);
      wr(0, 16'h0000);
    end
    repeat_dis <= 1'b1;
    wr(1, 16'h0000);
    rd(1, got);
    chk(got, 16'h4000);
    repeat_dis <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd(1, got);
    chk(got, 16'h0000);
    $display("test traps done");
    for (int pol = 0; pol < 2; pol++) begin
      for (int p = 0; p < 3; p++) begin
        fb = (p == 0) ? 0 : (p == 1) ? 20 : 29;
        w = 2 + fb / 16;
        wr(1, pol ? 16'h0007 : 16'h0000);
        ext_pin_in[p] <= pol[0];
        repeat (6) @(posedge clock_in);
        wr(2, 16'h0000);
        wr(3, 16'h0000);
        ext_pin_in[p] <= ~pol[0];
        repeat (6) @(posedge clock_in);
        rd(w, got);
        chk(got, 16'h0001 << (fb % 16));
        wr(w, 16'h0000);
        ext_pin_in[p] <= pol[0];
        repeat (6) @(posedge clock_in);
        rd(w, got);
        chk(got, 16'h0000);
      end
    end
    $display("test external edges done");
    give_verdict();
  end
endmodule
